/* logic/sdcd_decoder.sv */
// two-beat command decoder with field extraction and sticky illegal-sequence flag
`timescale 1ns/100ps
module sdcd_decoder
   import sdcd_pkg::*;
#(
   parameter logic BL_DEFAULT = 1'b0 // burst select when on-the-fly is off, 0 = 16
)(
   input wire logic mclk, // command clock
   input wire logic rst_n, // async reset, active low
   input wire logic cke, // clock enable pin, asynchronous
   input wire logic cs, // chip select
   input wire logic [5:0] ca, // command/address bus
   input wire logic otf_bl_en, // on-the-fly burst length enable
   output logic cmd_valid, // one-cycle pulse per completed command
   output sdcd_cmd_e cmd_kind, // completed command kind
   output logic [2:0] bank, // bank address
   output logic all_banks_flag, // precharge/refresh to every bank
   output logic auto_precharge_flag, // auto precharge after burst
   output logic burst_length_select, // 1 = 32 beats, 0 = 16 beats
   output logic [15:0] row, // row address on activate-2
   output logic [9:0] column, // column address on cas-2
   output logic [5:0] mr_addr, // mode register address
   output logic [7:0] mr_op, // mode register operand
   output logic [6:0] mpc_op, // mpc operand
   output logic seq_error // illegal sequence seen, held until reset
);

   logic cke_m;
   logic cke_s;
   sdcd_phase_e phase;
   sdcd_cmd_e first_cmd;
   sdcd_cmd_e cur_cmd;
   logic first_ca5;
   logic [3:0] first_hi; // ca5..ca2 of the latest first beat
   logic first_edge;
   logic desel;
   logic done;
   logic pair_err;
   logic c9_hold;
   logic [5:0] row_hi;
   logic op7_hold;

   assign cur_cmd = sdcd_decode(ca);
   assign first_edge = (phase == SDCD_PH_FIRST) && cs;
   assign desel = (phase == SDCD_PH_FIRST) && !cs;
   assign done = (phase == SDCD_PH_SECOND);

   // ==========================================================
   // clock enable synchroniser
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cke_m <= 1'b0;
         cke_s <= 1'b0;
      end else begin
         cke_m <= cke;
         cke_s <= cke_m;
      end
   end

   // ==========================================================
   // beat phase and first-beat capture
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         phase <= SDCD_PH_FIRST;
      end else begin
         unique case (phase)
            SDCD_PH_FIRST: if (cs) begin
               phase <= SDCD_PH_SECOND;
            end
            SDCD_PH_SECOND: phase <= SDCD_PH_FIRST;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         first_cmd <= SDCD_NONE;
         first_ca5 <= 1'b0;
         first_hi <= 4'h0;
      end else if (first_edge) begin
         first_cmd <= cur_cmd;
         first_ca5 <= ca[5];
         first_hi <= ca[5:2];
      end
   end

   sdcd_pair_track u_pair (
      .mclk(mclk),
      .rst_n(rst_n),
      .first_edge(first_edge),
      .desel(desel),
      .cmd(cur_cmd),
      .done(done),
      .done_cmd(first_cmd),
      .done_mpc({first_ca5, ca}),
      .pair_err(pair_err)
   );

   // ==========================================================
   // held halves of split fields
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         c9_hold <= 1'b0;
         row_hi <= 6'h00;
         op7_hold <= 1'b0;
      end else if (done) begin
         if (first_cmd == SDCD_WR1 || first_cmd == SDCD_MWR1 || first_cmd == SDCD_RD1) begin
            c9_hold <= ca[4];
         end
         if (first_cmd == SDCD_ACT1) begin
            row_hi <= {first_hi, ca[5], ca[4]};
         end
         if (first_cmd == SDCD_MRW1) begin
            op7_hold <= first_ca5;
         end
      end
   end

   // ==========================================================
   // decoded outputs on the second edge
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_valid <= 1'b0;
         cmd_kind <= SDCD_NONE;
         bank <= 3'h0;
         all_banks_flag <= 1'b0;
         auto_precharge_flag <= 1'b0;
         burst_length_select <= 1'b0;
         row <= 16'h0000;
         column <= 10'h000;
         mr_addr <= 6'h00;
         mr_op <= 8'h00;
         mpc_op <= 7'h00;
      end else begin
         cmd_valid <= done;
         if (done) begin
            cmd_kind <= first_cmd;
            unique case (first_cmd)
               SDCD_PRE, SDCD_REF: begin
                  all_banks_flag <= first_ca5;
                  if (!first_ca5) begin
                     bank <= ca[2:0];
                  end
               end
               SDCD_WR1, SDCD_RD1, SDCD_MWR1: begin
                  bank <= ca[2:0];
                  auto_precharge_flag <= ca[5];
                  if (first_cmd == SDCD_MWR1) begin
                     burst_length_select <= 1'b0;
                  end else begin
                     burst_length_select <= otf_bl_en ? first_ca5 : BL_DEFAULT;
                  end
               end
               SDCD_CAS2: column <= {c9_hold, first_ca5, ca, 2'h0};
               SDCD_MPC: mpc_op <= {first_ca5, ca};
               SDCD_ACT1: bank <= ca[2:0];
               SDCD_ACT2: row <= {row_hi, first_hi, ca};
               SDCD_MRW1, SDCD_MRR1: mr_addr <= ca;
               SDCD_MRW2: mr_op <= {op7_hold, first_ca5, ca};
               default: ;
            endcase
         end
      end
   end

   // ==========================================================
   // sticky illegal-sequence flag, cleared only by reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         seq_error <= 1'b0;
      end else if (pair_err || (done && cs) ||
                   (done && first_cmd == SDCD_RSVD) ||
                   ((first_edge || done) && !cke_s) ||
                   (done && first_cmd == SDCD_MWR1 && first_ca5)) begin
         seq_error <= 1'b1;
      end
   end

   // ==========================================================
   // assertions
   a_desel_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
      desel |=> !cmd_valid) else $error("deselect produced a command");
   a_two_edge_cmd: assert property (@(posedge mclk) disable iff (!rst_n)
      first_edge |=> !cmd_valid ##1 cmd_valid) else $error("command not two edges");
   a_pre_decode: assert property (@(posedge mclk) disable iff (!rst_n)
      first_edge && ca == {ca[5], 5'h10} |=> ##1 cmd_kind == SDCD_PRE)
      else $error("precharge misdecoded");
   a_act_decode: assert property (@(posedge mclk) disable iff (!rst_n)
      first_edge && ca[1:0] == 2'h1 |=> ##1 cmd_kind == SDCD_ACT1)
      else $error("activate-1 misdecoded");
   a_all_banks: assert property (@(posedge mclk) disable iff (!rst_n)
      done && first_cmd == SDCD_PRE |=> all_banks_flag == $past(first_ca5))
      else $error("all-banks flag wrong");
   a_read_fields: assert property (@(posedge mclk) disable iff (!rst_n)
      done && first_cmd == SDCD_RD1 |=> auto_precharge_flag == $past(ca[5]) &&
      bank == $past(ca[2:0])) else $error("read fields wrong");
   a_otf_burst: assert property (@(posedge mclk) disable iff (!rst_n)
      done && first_cmd == SDCD_WR1 && otf_bl_en |=> burst_length_select == $past(first_ca5))
      else $error("on-the-fly burst wrong");
   a_mwr_bl16: assert property (@(posedge mclk) disable iff (!rst_n)
      done && first_cmd == SDCD_MWR1 |=> !burst_length_select) else $error("masked burst not 16");
   a_cas_column: assert property (@(posedge mclk) disable iff (!rst_n)
      done && first_cmd == SDCD_CAS2 |=> column[1:0] == 2'h0 && column[7:2] == $past(ca))
      else $error("cas-2 column wrong");
   a_mrw_operand: assert property (@(posedge mclk) disable iff (!rst_n)
      done && first_cmd == SDCD_MRW2 |=> mr_op[5:0] == $past(ca)) else $error("mrw operand wrong");
   a_error_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
      seq_error |=> seq_error) else $error("error flag cleared without reset");
   a_row_fields: assert property (@(posedge mclk) disable iff (!rst_n)
      done && first_cmd == SDCD_ACT2 |=> row[5:0] == $past(ca) && row[9] == $past(first_ca5))
      else $error("activate-2 row wrong");
   a_mpc_operand: assert property (@(posedge mclk) disable iff (!rst_n)
      done && first_cmd == SDCD_MPC |=>
      mpc_op[5:0] == $past(ca) && mpc_op[6] == $past(first_ca5))
      else $error("mpc operand wrong");
   a_cs_second: assert property (@(posedge mclk) disable iff (!rst_n)
      done && cs |=> seq_error) else $error("chip select on second edge not flagged");
   a_pair_flag: assert property (@(posedge mclk) disable iff (!rst_n)
      pair_err |=> seq_error) else $error("pairing violation not flagged");
   a_bank_field: assert property (@(posedge mclk) disable iff (!rst_n)
      done && first_cmd == SDCD_REF && !first_ca5 |=> bank == $past(ca[2:0]))
      else $error("refresh bank wrong");

endmodule

/* logic/sdcd_pkg.sv */
// constants, command codes and first-beat decoder of the sdram command decoder
package sdcd_pkg;

   // ==========================================================
   // widths and counts
   localparam int SDCD_CA_W = 6;
   localparam int SDCD_BANK_W = 3;
   localparam int SDCD_ROW_W = 16;
   localparam int SDCD_COL_W = 10;
   localparam int SDCD_MA_W = 6;
   localparam int SDCD_OP_W = 8;
   localparam int SDCD_MPC_W = 7;
   localparam logic [1:0] SDCD_MPC_GAP = 2'h2;

   // ==========================================================
   // mpc operands that are followed by cas-2
   localparam logic [6:0] SDCD_MPC_RD_CAL = 7'h43;
   localparam logic [6:0] SDCD_MPC_WR_FIFO = 7'h47;
   localparam logic [6:0] SDCD_MPC_RD_FIFO = 7'h41;

   // ==========================================================
   // command kinds and phases
   typedef enum logic [3:0] {
      SDCD_NONE = 4'h0, SDCD_MPC = 4'h1, SDCD_PRE = 4'h2, SDCD_REF = 4'h3,
      SDCD_SRE = 4'h4, SDCD_WR1 = 4'h5, SDCD_SRX = 4'h6, SDCD_MWR1 = 4'h7,
      SDCD_RD1 = 4'h8, SDCD_CAS2 = 4'h9, SDCD_MRW1 = 4'ha, SDCD_MRW2 = 4'hb,
      SDCD_MRR1 = 4'hc, SDCD_ACT1 = 4'hd, SDCD_ACT2 = 4'he, SDCD_RSVD = 4'hf
   } sdcd_cmd_e;

   typedef enum logic {
      SDCD_PH_FIRST = 1'b0,
      SDCD_PH_SECOND = 1'b1
   } sdcd_phase_e;

   // ==========================================================
   // first-beat classification, select read as ca2 ca3 ca4
   function automatic sdcd_cmd_e sdcd_decode(input logic [5:0] ca);
      sdcd_cmd_e k;
      k = SDCD_RSVD;
      if (ca[0]) begin
         k = ca[1] ? SDCD_ACT2 : SDCD_ACT1;
      end else if (!ca[1]) begin
         unique case ({ca[2], ca[3], ca[4]})
            3'h0: k = SDCD_MPC;
            3'h1: k = SDCD_PRE;
            3'h2: k = SDCD_REF;
            3'h3: k = SDCD_SRE;
            3'h4: k = SDCD_WR1;
            3'h5: k = SDCD_SRX;
            3'h6: k = SDCD_MWR1;
            3'h7: k = SDCD_RSVD;
         endcase
      end else begin
         unique case ({ca[2], ca[3], ca[4]})
            3'h0: k = SDCD_RD1;
            3'h1: k = SDCD_CAS2;
            3'h4: k = SDCD_MRW1;
            3'h5: k = SDCD_MRW2;
            3'h6: k = SDCD_MRR1;
            default: k = SDCD_RSVD;
         endcase
      end
      return k;
   endfunction

endpackage

/* logic/sdcd_pair_track.sv */
// tracker of mandatory first/second half pairing and post-mpc idle gap
`timescale 1ns/100ps
module sdcd_pair_track
   import sdcd_pkg::*;
(
   input wire logic mclk, // command clock
   input wire logic rst_n, // async reset, active low
   input wire logic first_edge, // chip select high on a first edge
   input wire logic desel, // deselect edge
   input wire sdcd_cmd_e cmd, // kind decoded on this first edge
   input wire logic done, // second edge of a command
   input wire sdcd_cmd_e done_cmd, // kind being completed
   input wire logic [6:0] done_mpc, // mpc operand being completed
   output logic pair_err // high the cycle after each violating edge, held through deselects while a half is pending
);

   logic need_cas;
   logic need_act2;
   logic need_mrw2;
   logic [1:0] gap;
   logic mpc_cas;

   assign mpc_cas = (done_mpc == SDCD_MPC_RD_CAL) || (done_mpc == SDCD_MPC_WR_FIFO) ||
                    (done_mpc == SDCD_MPC_RD_FIFO);

   // ==========================================================
   // pending second halves
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         need_cas <= 1'b0;
         need_act2 <= 1'b0;
         need_mrw2 <= 1'b0;
      end else if (first_edge) begin
         need_cas <= 1'b0;
         need_act2 <= 1'b0;
         need_mrw2 <= 1'b0;
      end else if (done) begin
         need_cas <= (done_cmd == SDCD_WR1) || (done_cmd == SDCD_MWR1) ||
                     (done_cmd == SDCD_RD1) || (done_cmd == SDCD_MRR1) ||
                     (done_cmd == SDCD_MPC && mpc_cas);
         need_act2 <= (done_cmd == SDCD_ACT1);
         need_mrw2 <= (done_cmd == SDCD_MRW1);
      end
   end

   // ==========================================================
   // idle gap after oscillator and calibration mpc
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gap <= 2'h0;
      end else if (done && done_cmd == SDCD_MPC && !mpc_cas) begin
         gap <= SDCD_MPC_GAP;
      end else if ((desel || first_edge) && gap != 2'h0) begin
         gap <= gap - 2'h1;
      end
   end

   // ==========================================================
   // violation pulse
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pair_err <= 1'b0;
      end else begin
         pair_err <= (first_edge && ((need_cas != (cmd == SDCD_CAS2)) ||
                                     (need_act2 != (cmd == SDCD_ACT2)) ||
                                     (need_mrw2 != (cmd == SDCD_MRW2)) ||
                                     gap != 2'h0)) ||
                     (desel && (need_cas || need_act2 || need_mrw2));
      end
   end

endmodule

/* tb/sdcd_ctrl_model.sv */
// controller-side model driving clock enable, chip select and command/address bus
`timescale 1ns/100ps
module sdcd_ctrl_model (
   input wire logic mclk, // command clock
   output logic cke, // clock enable, high from start, driven to a new level by set_cke
   output logic cs, // chip select
   output logic [5:0] ca // command/address bus
);
   // ==========================================================
   // idle levels
   initial begin
      cke = 1'b1;
      cs = 1'b0;
      ca = 6'h00;
   end

   // ==========================================================
   // one two-beat command, every position at a defined level
   task automatic cmd(input logic [5:0] first, input logic [5:0] second);
      @(posedge mclk);
      #1;
      cs = 1'b1;
      ca = first;
      @(posedge mclk);
      #1;
      cs = 1'b0;
      ca = second;
   endtask

   // deselect cycles; don't-care lines toggle so no stale value is relied on
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge mclk);
         #1;
         cs = 1'b0;
         ca = ~ca;
      end
   endtask

   // one edge of raw bus levels, used to build illegal sequences
   task automatic raw(input logic c, input logic [5:0] v);
      @(posedge mclk);
      #1;
      cs = c;
      ca = v;
   endtask

   // clock enable level, changed only while the bus is deselected
   task automatic set_cke(input logic v);
      @(posedge mclk);
      #1;
      cke = v;
   endtask
endmodule

/* tb/testbench.sv */
// self-checking bench for the two-beat command decoder
`timescale 1ns/100ps
module testbench;
   import sdcd_pkg::*;
   logic mclk, rst_n, otf_bl_en, cke, cs;
   logic [5:0] ca;
   logic cmd_valid, all_banks_flag, auto_precharge_flag, burst_length_select, seq_error;
   sdcd_cmd_e cmd_kind;
   logic [2:0] bank;
   logic [15:0] row;
   logic [9:0] column;
   logic [5:0] mr_addr;
   logic [7:0] mr_op;
   logic [6:0] mpc_op;
   int mismatches = 0;
   int checked = 0;
   int pulses = 0;
   int exp_pulses = 0;
   int cycles = 0;
   logic [5:0] kf [5] = '{6'b110000, 6'b001000, 6'b011000, 6'b010100, 6'b000000};
   logic [5:0] ks [5] = '{6'h00, 6'h05, 6'h00, 6'h00, 6'h05};
   sdcd_cmd_e kk [5] = '{SDCD_PRE, SDCD_REF, SDCD_SRE, SDCD_SRX, SDCD_MPC};
   logic [5:0] ef [7] = '{6'h12, 6'h2c, 6'h1c, 6'h00, 6'h01, 6'h04, 6'h26};
   logic [5:0] e2 [7] = '{6'h00, 6'h12, 6'h00, 6'h30, 6'h02, 6'h30, 6'h30};
   logic two [7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

   sdcd_ctrl_model sdcd_ctrl_model_inst (.mclk(mclk), .cke(cke), .cs(cs), .ca(ca));
   sdcd_decoder sdcd_decoder_inst (.mclk(mclk), .rst_n(rst_n), .cke(cke), .cs(cs), .ca(ca),
      .otf_bl_en(otf_bl_en), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .bank(bank),
      .all_banks_flag(all_banks_flag), .auto_precharge_flag(auto_precharge_flag),
      .burst_length_select(burst_length_select), .row(row), .column(column),
      .mr_addr(mr_addr), .mr_op(mr_op), .mpc_op(mpc_op), .seq_error(seq_error));

   // ==========================================================
   // clock, pulse counter, timeout
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   always @(negedge mclk) if (cmd_valid === 1'b1) pulses++;
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         wrap_up();
      end
   end

   // ==========================================================
   // tasks
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
         mismatches++;
      end
   endtask
   task automatic do_reset();
      rst_n = 1'b0;
      repeat (8) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      repeat (3) @(posedge mclk);
      #1;
   endtask
   task automatic pair(input logic [5:0] f, input logic [5:0] s, input int n);
      sdcd_ctrl_model_inst.cmd(f, s);
      exp_pulses++;
      if (n > 0) sdcd_ctrl_model_inst.idle(n);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // ==========================================================
   // tests
   initial begin
      rst_n = 1'b0;
      otf_bl_en = 1'b0;
      do_reset();
      chk("kind", 16'(SDCD_NONE), 16'(cmd_kind));
      for (int i = 0; i < 5; i++) begin
         pair(kf[i], ks[i], 3);
         chk("kind", 16'(kk[i]), 16'(cmd_kind));
         if (i < 2) chk("all_banks", 16'(i == 0), 16'(all_banks_flag));
      end
      chk("bank", 16'h5, 16'(bank));
      chk("mpc_op", 16'h05, 16'(mpc_op));
      $display("test single-beat kinds done");
      otf_bl_en = 1'b1;
      pair(6'b100100, 6'b110011, 0);
      pair(6'b110010, 6'b101100, 2);
      chk("kind", 16'(SDCD_CAS2), 16'(cmd_kind));
      chk("bank", 16'h3, 16'(bank));
      chk("ap", 16'h1, 16'(auto_precharge_flag));
      chk("bl", 16'h1, 16'(burst_length_select));
      chk("column", 16'h3b0, 16'(column));
      otf_bl_en = 1'b0;
      pair(6'b100010, 6'b000110, 0);
      pair(6'b010010, 6'b111111, 2);
      chk("bl", 16'h0, 16'(burst_length_select));
      chk("bank", 16'h6, 16'(bank));
      chk("ap", 16'h0, 16'(auto_precharge_flag));
      chk("column", 16'h0fc, 16'(column));
      pair(6'b001100, 6'b000001, 0);
      pair(6'b010010, 6'b000000, 2);
      chk("bank", 16'h1, 16'(bank));
      $display("test column access done");
      pair(6'b100110, 6'h2a, 0);
      pair(6'b010110, 6'h15, 2);
      chk("kind", 16'(SDCD_MRW2), 16'(cmd_kind));
      chk("mr_addr", 16'h2a, 16'(mr_addr));
      chk("mr_op", 16'h95, 16'(mr_op));
      pair(6'b001110, 6'h11, 0);
      pair(6'b010010, 6'h00, 2);
      chk("mr_addr", 16'h11, 16'(mr_addr));
      pair(6'b110101, 6'b100010, 0);
      pair(6'b011011, 6'h2d, 2);
      chk("kind", 16'(SDCD_ACT2), 16'(cmd_kind));
      chk("bank", 16'h2, 16'(bank));
      chk("row", 16'hd9ad, 16'(row));
      pair(6'b100000, 6'h03, 0);
      pair(6'b010010, 6'h00, 2);
      chk("mpc_op", 16'h43, 16'(mpc_op));
      chk("pulses", 16'(exp_pulses), 16'(pulses));
      chk("seq_error", 16'h0, 16'(seq_error));
      $display("test paired commands done");
      for (int i = 0; i < 7; i++) begin
         do_reset();
         sdcd_ctrl_model_inst.cmd(ef[i], 6'h00);
         if (two[i]) sdcd_ctrl_model_inst.cmd(e2[i], 6'h00);
         sdcd_ctrl_model_inst.idle(4);
         chk("seq_error", 16'h1, 16'(seq_error));
         pair(6'b110000, 6'h00, 3);
         chk("seq_error", 16'h1, 16'(seq_error));
      end
      sdcd_ctrl_model_inst.set_cke(1'b0);
      do_reset();
      pair(6'b110000, 6'h00, 3);
      chk("seq_error", 16'h1, 16'(seq_error));
      sdcd_ctrl_model_inst.set_cke(1'b1);
      do_reset();
      sdcd_ctrl_model_inst.raw(1'b1, 6'b110000);
      sdcd_ctrl_model_inst.raw(1'b1, 6'h00);
      sdcd_ctrl_model_inst.idle(3);
      chk("seq_error", 16'h1, 16'(seq_error));
      do_reset();
      chk("seq_error", 16'h0, 16'(seq_error));
      $display("test illegal sequences done");
      wrap_up();
   end
endmodule
